// File: core/fcd_pkg.sv
/*
  Shared constants and types for the floating-point command decoder:
  command word field layout, first-source codes, rounding methods,
  data register layout, exception kinds and controller states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcd_pkg;

  localparam int CMD_W = 32;
  localparam int WORD_W = 32;
  localparam int DR_WORDS = 3;
  localparam int DR_W = 96;
  localparam int EXT_W = 80;
  localparam int SIG_W = 64;
  localparam int EXP_W = 17;
  localparam int LGRS_W = 4;

  // Command word fields
  localparam int FS_LSB = 7;
  localparam int FS_W = 3;
  localparam int FS_MEM_BIT = 2;
  localparam int OPC_LSB = 10;
  localparam int OPC_W = 5;
  localparam int RC_LO_BIT = 15;
  localparam int RC_HI_BIT = 16;
  localparam int RCS_BIT = 17;
  localparam int BANK_LSB = 18;
  localparam int BANK_W = 3;
  localparam int FIRST_BANK_BIT = 20;
  localparam int UNUSED_LSB = 21;
  localparam int UNUSED_W = 3;
  localparam int UID_LSB = 24;
  localparam int UID_W = 8;

  // First-source codes
  localparam logic [2:0] FS_MEM1 = 3'h4;
  localparam logic [2:0] FS_MEM2 = 3'h5;
  localparam logic [2:0] FS_MEM3 = 3'h6;
  localparam logic [2:0] FS_NONE = 3'h7;

  // Data register layout during overflow, underflow, divide by zero or inexact
  localparam int LGRS_LSB = 92;
  localparam int SIGN_POS = 81;
  localparam int EXP_LSB = 64;
  localparam int GAP_W = 10;
  localparam int PAD_W = 12;

  // Peripheral word selects
  localparam logic [1:0] SEL_CR = 2'h0;

  typedef enum logic [1:0] {
    FCD_RND_NEAREST = 2'h0,
    FCD_RND_POS_INF = 2'h1,
    FCD_RND_NEG_INF = 2'h2,
    FCD_RND_ZERO = 2'h3
  } fcd_round_e;

  typedef enum logic [1:0] {
    FCD_EXC_INVALID = 2'h0,
    FCD_EXC_OVF_UNF = 2'h1,
    FCD_EXC_DIV_ZERO = 2'h2,
    FCD_EXC_INEXACT = 2'h3
  } fcd_exc_e;

  typedef enum logic [2:0] {
    FCD_ST_QUIET = 3'b001,
    FCD_ST_PERIPH = 3'b010,
    FCD_ST_COPROC = 3'b100
  } fcd_state_e;

endpackage

// File: core/fcd_dr_if.sv
/*
  Interface between the decoder and its data register storage.
  Assumes both ends share ref_clk and the synchronised reset.
*/
`timescale 1ns/1ns
interface fcd_dr_if #(
  parameter int WORD_W = 32,
  parameter int WORDS = 3
);
  logic ce;
  logic [WORDS-1:0] wr_en;
  logic [WORDS*WORD_W-1:0] wr_data;
  logic rd_en;
  logic [1:0] rd_idx;
  logic [WORD_W-1:0] rd_data;

  modport ctl (output ce, wr_en, wr_data, rd_en, rd_idx, input rd_data);
  modport mem (input ce, wr_en, wr_data, rd_en, rd_idx, output rd_data);
endinterface

// File: core/fcd_dr_mem.sv
/*
  Word storage of the 96-bit data register, one word per entry,
  with per-word write enables and a registered read port.
  Assumes a synchronised active-low reset and the controller's clock enable.
*/
`timescale 1ns/1ns
module fcd_dr_mem #(
  parameter int WORD_W = 32,
  parameter int WORDS = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  fcd_dr_if.mem port
);

  logic [WORD_W-1:0] word [WORDS];
  logic [WORD_W-1:0] next_word [WORDS];
  logic [WORD_W-1:0] rd_q;
  logic [WORD_W-1:0] next_rd_q;

  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      always_comb begin
        next_word[gi] = word[gi];
        if (port.ce && port.wr_en[gi]) begin
          next_word[gi] = port.wr_data[gi*WORD_W +: WORD_W];
        end
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          word[gi] <= '0;
        end else begin
          word[gi] <= next_word[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    next_rd_q = rd_q;
    if (port.ce && port.rd_en && (int'(port.rd_idx) < WORDS)) begin
      next_rd_q = word[port.rd_idx];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_q <= '0;
    end else begin
      rd_q <= next_rd_q;
    end
  end

  assign port.rd_data = rd_q;

endmodule

// File: core/fcd_top.sv
/*
  Command word decoder and fault data register of a floating-point
  coprocessor. Takes commands by peripheral write or coprocessor broadcast,
  decodes the fields, tracks the transaction and loads trap data on faults.
  Assumes all inputs other than nrst_in are synchronous to ref_clk_in;
  the arithmetic datapath supplies operands already widened to 80 bits.
*/
// Notes on behaviour
// - First source codes 000-011 pick F0-F3 or F4-F7 by first bank select.
// - First source 100/101/110 are one/two/three memory words, 111 none.
// - Operation code comes from command bits 10 to 14.
// - Command rounding: 00 nearest, 01 plus, 10 minus infinity, 11 zero.
// - Bit 17 clear rounds by the status register's rounding field.
// - Bit 17 set rounds by command field; status field left untouched.
// - Bits 18, 19, 20 each pick bank F0-F3 (0) or F4-F7 (1).
// - Command register bits 21 to 23 read back as zero.
// - Commands are acted on only when bits 24-31 match our unit number.
// - Data register is three 32-bit words reached by peripheral accesses.
// - Exceptions load trap data into the data register for host extraction.
// - Invalid with one trapping NaN stores that NaN in 80-bit form.
// - Both trapping NaNs or opposite infinities store second operand.
// - Overflow/underflow store significand, sign, 17-bit biased signed exponent.
// - Overflow layout: LGRS 95-92, unused 91-82, sign 81, exponent 80-64.
// - Divide by zero stores dividend plus LGRS in bits 95 to 92.
// - Inexact stores rounded result plus LGRS in bits 95 to 92.
// - Peripheral command write starts a transaction; acknowledges then ignored.
// - Coprocessor operation aborts to quiet on an acknowledge cycle.
`timescale 1ns/1ns
module fcd_top
  import fcd_pkg::*;
#(
  parameter logic [UID_W-1:0] UNIT_ID = 8'h5A // Arbitrary value
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic per_wr_in,
  input wire logic per_rd_in,
  input wire logic [1:0] per_sel_in,
  input wire logic [WORD_W-1:0] per_wdata_in,
  input wire logic cop_cmd_valid_in,
  input wire logic [CMD_W-1:0] cop_cmd_in,
  input wire logic iack_in,
  input wire logic op_done_in,
  input wire logic [1:0] asr_round_in,
  input wire logic exc_valid_in,
  input wire logic [1:0] exc_kind_in,
  input wire logic exc_op1_tnan_in,
  input wire logic exc_op2_tnan_in,
  input wire logic exc_opp_inf_in,
  input wire logic [EXT_W-1:0] exc_op1_ext_in,
  input wire logic [EXT_W-1:0] exc_op2_ext_in,
  input wire logic [LGRS_W-1:0] exc_lgrs_in,
  input wire logic exc_sign_in,
  input wire logic [EXP_W-1:0] exc_exp_in,
  input wire logic [SIG_W-1:0] exc_signif_in,
  input wire logic [EXT_W-1:0] exc_rounded_in,
  output logic [WORD_W-1:0] per_rdata_out,
  output logic per_rvalid_out,
  output logic cmd_start_out,
  output logic txn_active_out,
  output logic coproc_mode_out,
  output logic abort_out,
  output logic first_source_is_reg_out,
  output logic [2:0] first_source_fnum_out,
  output logic [1:0] first_source_words_out,
  output logic first_source_none_out,
  output logic [OPC_W-1:0] opcode_out,
  output logic [1:0] rounding_method_out,
  output logic [BANK_W-1:0] operand_bank_selects_out,
  output logic fault_held_out
);

  // Reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  fcd_dr_if #(.WORD_W(WORD_W), .WORDS(DR_WORDS)) dr_bus ();

  fcd_dr_mem #(.WORD_W(WORD_W), .WORDS(DR_WORDS)) u_dr_mem (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .port(dr_bus.mem)
  );

  // Command acceptance
  logic per_cr_wr;
  logic per_id_ok;
  logic cop_id_ok;
  logic accept;
  logic [CMD_W-1:0] acc_word;

  assign per_cr_wr = per_wr_in && (per_sel_in == SEL_CR);
  assign per_id_ok = per_wdata_in[UID_LSB +: UID_W] == UNIT_ID;
  assign cop_id_ok = cop_cmd_in[UID_LSB +: UID_W] == UNIT_ID;
  assign accept = (per_cr_wr && per_id_ok) || (cop_cmd_valid_in && cop_id_ok);
  // Peripheral write takes priority if both arrive together
  assign acc_word = (per_cr_wr && per_id_ok) ? per_wdata_in : cop_cmd_in;

  // Fault data assembly
  logic [DR_W-1:0] fault_word;
  logic [EXT_W-1:0] invalid_pick;

  always_comb begin
    invalid_pick = exc_op2_ext_in;
    if ((exc_op1_tnan_in && exc_op2_tnan_in) || exc_opp_inf_in) begin
      invalid_pick = exc_op2_ext_in;
    end else if (exc_op1_tnan_in) begin
      invalid_pick = exc_op1_ext_in;
    end
    case (fcd_exc_e'(exc_kind_in))
      FCD_EXC_INVALID: begin
        fault_word = {{(DR_W - EXT_W){1'b0}}, invalid_pick};
      end
      FCD_EXC_OVF_UNF: begin
        // Wide exponent keeps its top bit as sign, nothing clipped
        fault_word = {exc_lgrs_in, {GAP_W{1'b0}}, exc_sign_in, exc_exp_in, exc_signif_in};
      end
      FCD_EXC_DIV_ZERO: begin
        fault_word = {exc_lgrs_in, {PAD_W{1'b0}}, exc_op2_ext_in};
      end
      FCD_EXC_INEXACT: begin
        fault_word = {exc_lgrs_in, {PAD_W{1'b0}}, exc_rounded_in};
      end
      default: begin
        fault_word = '0;
      end
    endcase
  end

  // Control state
  fcd_state_e state;
  fcd_state_e next_state;
  logic [CMD_W-1:0] cr;
  logic [CMD_W-1:0] next_cr;
  logic fault_held;
  logic next_fault_held;
  logic rd_p1;
  logic next_rd_p1;
  logic [1:0] sel_p1;
  logic [1:0] next_sel_p1;
  logic [WORD_W-1:0] next_per_rdata;
  logic next_per_rvalid;
  logic next_cmd_start;
  logic next_abort;
  logic next_fs_is_reg;
  logic [2:0] next_fs_fnum;
  logic [1:0] next_fs_words;
  logic next_fs_none;
  logic [OPC_W-1:0] next_opcode;
  logic [1:0] next_round;
  logic [BANK_W-1:0] next_banks;
  logic [2:0] acc_fs;
  logic dr_rd;
  logic dr_wr;
  logic [WORD_W-1:0] cr_view;
  // Next values of the status outputs
  logic next_txn_active;
  logic next_coproc_mode;

  assign acc_fs = acc_word[FS_LSB +: FS_W];
  assign dr_rd = per_rd_in && (per_sel_in != SEL_CR);
  assign dr_wr = per_wr_in && (per_sel_in != SEL_CR);
  // Unused field never reflects what was written
  assign cr_view = cr & ~({{(CMD_W - UNUSED_W){1'b0}}, {UNUSED_W{1'b1}}} << UNUSED_LSB);

  // Data register port; one word per peripheral address
  always_comb begin
    dr_bus.ce = ce_in;
    dr_bus.rd_en = dr_rd;
    dr_bus.rd_idx = per_sel_in - 2'h1;
    dr_bus.wr_en = '0;
    dr_bus.wr_data = {DR_WORDS{per_wdata_in}};
    if (exc_valid_in) begin
      // Trap data overwrites any host write in the same cycle
      dr_bus.wr_en = '1;
      dr_bus.wr_data = fault_word;
    end else if (dr_wr && !fault_held) begin
      dr_bus.wr_en = DR_WORDS'(1) << (per_sel_in - 2'h1);
    end
  end

  // Read answer pipe; data stands until the next answer
  always_comb begin
    next_rd_p1 = per_rd_in;
    next_sel_p1 = per_sel_in;
    next_per_rdata = per_rdata_out;
    next_per_rvalid = rd_p1;
    if (rd_p1) begin
      next_per_rdata = (sel_p1 == SEL_CR) ? cr_view : dr_bus.rd_data;
    end
  end

  // Transaction tracking and held fault data
  always_comb begin
    next_state = state;
    next_cr = cr;
    next_fault_held = fault_held;
    next_cmd_start = accept;
    next_abort = 1'b0;

    case (state)
      FCD_ST_QUIET, FCD_ST_PERIPH: begin
        // Acknowledge cycles ignored here
        next_state = state;
      end
      FCD_ST_COPROC: begin
        if (iack_in) begin
          next_state = FCD_ST_QUIET;
          next_abort = 1'b1;
        end else if (op_done_in) begin
          next_state = FCD_ST_QUIET;
        end
      end
      default: begin
        next_state = FCD_ST_QUIET;
      end
    endcase

    // A new command beats an acknowledge in the same cycle
    if (accept) begin
      next_cr = acc_word;
      next_abort = 1'b0;
      next_state = (per_cr_wr && per_id_ok) ? FCD_ST_PERIPH : FCD_ST_COPROC;
    end

    // Status flags follow the next state so both change on one edge
    next_txn_active = next_state != FCD_ST_QUIET;
    next_coproc_mode = next_state == FCD_ST_COPROC;

    // Held fault data: set beats clear
    if (dr_rd || accept) begin
      next_fault_held = 1'b0;
    end
    if (exc_valid_in) begin
      next_fault_held = 1'b1;
    end
  end

  // Decoded fields stand until the next accepted command
  always_comb begin
    next_fs_is_reg = first_source_is_reg_out;
    next_fs_fnum = first_source_fnum_out;
    next_fs_words = first_source_words_out;
    next_fs_none = first_source_none_out;
    next_opcode = opcode_out;
    next_banks = operand_bank_selects_out;
    if (accept) begin
      next_opcode = acc_word[OPC_LSB +: OPC_W];
      next_banks = acc_word[BANK_LSB +: BANK_W];
      next_fs_is_reg = !acc_fs[FS_MEM_BIT];
      // Register number loads for memory codes too; users gate it with is_reg
      next_fs_fnum = {acc_word[FIRST_BANK_BIT], acc_fs[1:0]};
      next_fs_none = acc_fs == FS_NONE;
      case (acc_fs)
        FS_MEM1: next_fs_words = 2'h1;
        FS_MEM2: next_fs_words = 2'h2;
        FS_MEM3: next_fs_words = 2'h3;
        default: next_fs_words = 2'h0;
      endcase
    end
  end

  // Rounding source; the status register field is only read, never written
  always_comb begin
    if (cr[RCS_BIT]) begin
      next_round = {cr[RC_LO_BIT], cr[RC_HI_BIT]};
    end else begin
      next_round = asr_round_in;
    end
  end

  // Read pipe freezes with ce_in low, so a stalled answer is not lost
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_p1 <= 1'b0;
      sel_p1 <= SEL_CR;
      per_rdata_out <= '0;
      per_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      rd_p1 <= next_rd_p1;
      sel_p1 <= next_sel_p1;
      per_rdata_out <= next_per_rdata;
      per_rvalid_out <= next_per_rvalid;
    end
  end

  // Transaction state
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= FCD_ST_QUIET;
      cr <= '0;
      fault_held <= 1'b0;
      cmd_start_out <= 1'b0;
      abort_out <= 1'b0;
      txn_active_out <= 1'b0;
      coproc_mode_out <= 1'b0;
      fault_held_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      cr <= next_cr;
      fault_held <= next_fault_held;
      cmd_start_out <= next_cmd_start;
      abort_out <= next_abort;
      txn_active_out <= next_txn_active;
      coproc_mode_out <= next_coproc_mode;
      fault_held_out <= next_fault_held;
    end
  end

  // Decoded command fields
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      first_source_is_reg_out <= 1'b0;
      first_source_fnum_out <= '0;
      first_source_words_out <= '0;
      first_source_none_out <= 1'b0;
      opcode_out <= '0;
      rounding_method_out <= FCD_RND_NEAREST;
      operand_bank_selects_out <= '0;
    end else if (ce_in) begin
      first_source_is_reg_out <= next_fs_is_reg;
      first_source_fnum_out <= next_fs_fnum;
      first_source_words_out <= next_fs_words;
      first_source_none_out <= next_fs_none;
      opcode_out <= next_opcode;
      rounding_method_out <= next_round;
      operand_bank_selects_out <= next_banks;
    end
  end

endmodule

// File: testbench/fcd_host_model.sv
/*
  Host model: peripheral writes and reads of the command and data words.
  Assumes the block answers a read within a few cycles.
*/
`timescale 1ns/1ns
module fcd_host_model (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_out,
  output logic rd_out,
  output logic [1:0] sel_out,
  output logic [31:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    sel_out = 2'h0;
    wdata_out = 32'h0;
  end
  // Word 0 starts a transaction, words 1-3 carry data
  task automatic wr(input logic [1:0] sel, input logic [31:0] data);
    @(negedge clk_in);
    wr_out = 1'b1;
    sel_out = sel;
    wdata_out = data;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~data; // Released bus never shows the old value
  endtask
  // Bounded wait for the answer
  task automatic rd(input logic [1:0] sel, output logic [31:0] data, output logic ok);
    ok = 1'b0;
    data = 32'h0;
    @(negedge clk_in);
    rd_out = 1'b1;
    sel_out = sel;
    @(negedge clk_in);
    rd_out = 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_in);
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        data = rdata_in;
      end
    end
  endtask
endmodule

// File: testbench/fcd_top_props.sv
/*
  Checker for the command decoder, bound to its top module.
  Assumes one-cycle host strobes and no request during reset.
*/
`timescale 1ns/1ns
module fcd_top_props
  import fcd_pkg::*;
#(
  parameter logic [UID_W-1:0] UNIT_ID = 8'h5A
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic per_wr_in,
  input wire logic per_rd_in,
  input wire logic [1:0] per_sel_in,
  input wire logic [WORD_W-1:0] per_wdata_in,
  input wire logic cop_cmd_valid_in,
  input wire logic iack_in,
  input wire logic [WORD_W-1:0] per_rdata_out,
  input wire logic per_rvalid_out,
  input wire logic cmd_start_out,
  input wire logic txn_active_out,
  input wire logic coproc_mode_out,
  input wire logic abort_out,
  input wire logic first_source_is_reg_out,
  input wire logic [2:0] first_source_fnum_out,
  input wire logic first_source_none_out,
  input wire logic [OPC_W-1:0] opcode_out,
  input wire logic [1:0] rounding_method_out,
  input wire logic [BANK_W-1:0] operand_bank_selects_out,
  input wire logic fault_held_out
);
  logic acc;
  assign acc = ce_in && per_wr_in && per_sel_in == 2'h0 && per_wdata_in[31:24] == UNIT_ID;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  start_on_match_a: assert property (acc |=> cmd_start_out && txn_active_out)
    else $error("no start after matching write");
  field_decode_a: assert property (acc |=> opcode_out == $past(per_wdata_in[14:10]) &&
    operand_bank_selects_out == $past(per_wdata_in[20:18])) else $error("opcode or banks wrong");
  first_source_a: assert property (acc |=> first_source_is_reg_out == !$past(per_wdata_in[9]) &&
    first_source_none_out == ($past(per_wdata_in[9:7]) == 3'h7) && (!first_source_is_reg_out ||
    first_source_fnum_out == {$past(per_wdata_in[20]), $past(per_wdata_in[8:7])})) else $error("first source wrong");
  cmd_round_a: assert property (acc && per_wdata_in[17] ##1 !per_wr_in && !cop_cmd_valid_in |=>
    rounding_method_out == {$past(per_wdata_in[15], 2), $past(per_wdata_in[16], 2)}) else $error("rounding wrong");
  unused_zero_a: assert property (ce_in && per_rd_in && per_sel_in == 2'h0 |->
    ##2 per_rvalid_out && per_rdata_out[23:21] == 3'h0) else $error("command read wrong");
  iack_abort_a: assert property (ce_in && coproc_mode_out && iack_in && !cop_cmd_valid_in && !per_wr_in
    |=> abort_out && !txn_active_out && !coproc_mode_out) else $error("no abort on acknowledge");
  iack_ignored_a: assert property (ce_in && txn_active_out && !coproc_mode_out && iack_in && !cop_cmd_valid_in
    && !per_wr_in |=> !abort_out && txn_active_out) else $error("acknowledge not ignored");
  fault_hold_a: assert property (fault_held_out && !per_rd_in && !per_wr_in && !cop_cmd_valid_in
    |=> fault_held_out) else $error("fault hold lost");
endmodule
bind fcd_top fcd_top_props #(.UNIT_ID(UNIT_ID)) u_props (.ref_clk_in, .nrst_in, .ce_in, .per_wr_in, .per_rd_in,
  .per_sel_in, .per_wdata_in, .cop_cmd_valid_in, .iack_in, .per_rdata_out, .per_rvalid_out, .cmd_start_out,
  .txn_active_out, .coproc_mode_out, .abort_out, .first_source_is_reg_out, .first_source_fnum_out,
  .first_source_none_out, .opcode_out, .rounding_method_out, .operand_bank_selects_out, .fault_held_out);

// File: testbench/fcd_top_bench.sv
/*
  Bench for the command decoder: host model, datapath stimulus, checks.
  Assumes the checker binds itself to the top module.
*/
`timescale 1ns/1ns
module fcd_top_bench
  import fcd_pkg::*;
;
  localparam logic [7:0] UNIT = 8'h5A; // Arbitrary value
  logic clk, rst_n, ce, wr, rd, cv, iack, done, ev, t1, t2, oi, sg;
  logic [1:0] sel, arith_status_reg, kind;
  logic [31:0] wd, cc;
  logic [79:0] op1, op2, rnd;
  logic [3:0] lgrs;
  logic [16:0] ex;
  logic [63:0] sig;
  logic [31:0] rdat, rst_word;
  logic rv, st, ta, cm, ab, isr, fnone, fh;
  logic [2:0] fnum, bks;
  logic [1:0] fw, rm;
  logic [4:0] opc;
  int errors = 0;
  int total_checks = 0;
  fcd_top #(.UNIT_ID(UNIT)) DUT (.ref_clk_in(clk), .nrst_in(rst_n), .ce_in(ce), .per_wr_in(wr), .per_rd_in(rd),
    .per_sel_in(sel), .per_wdata_in(wd), .cop_cmd_valid_in(cv), .cop_cmd_in(cc), .iack_in(iack), .op_done_in(done),
    .asr_round_in(arith_status_reg), .exc_valid_in(ev), .exc_kind_in(kind), .exc_op1_tnan_in(t1), .exc_op2_tnan_in(t2),
    .exc_opp_inf_in(oi), .exc_op1_ext_in(op1), .exc_op2_ext_in(op2), .exc_lgrs_in(lgrs), .exc_sign_in(sg),
    .exc_exp_in(ex), .exc_signif_in(sig), .exc_rounded_in(rnd), .per_rdata_out(rdat), .per_rvalid_out(rv),
    .cmd_start_out(st), .txn_active_out(ta), .coproc_mode_out(cm), .abort_out(ab), .first_source_is_reg_out(isr),
    .first_source_fnum_out(fnum), .first_source_words_out(fw), .first_source_none_out(fnone), .opcode_out(opc),
    .rounding_method_out(rm), .operand_bank_selects_out(bks), .fault_held_out(fh));
  fcd_host_model hst (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .wr_out(wr), .rd_out(rd), .sel_out(sel),
    .wdata_out(wd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [95:0] e, input logic [95:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd_word(input logic [1:0] s, output logic [31:0] v);
    logic ok;
    hst.rd(s, v, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value read answer expected 1 seen 0");
      stop_test();
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_decode();
    logic [31:0] w;
    for (int c = 0; c < 8; c++) begin
      w = {UNIT, 3'h0, 3'(c ^ 5), 3'h0, 5'(c * 3 + 1), 3'(c), 7'h0};
      hst.wr(2'h0, w);
      chk("start", 96'h1, st);
      chk("opcode", w[14:10], opc);
      chk("banks", w[20:18], bks);
      chk("is reg", !w[9], isr);
      if (!w[9]) chk("fnum", {w[20], w[8:7]}, fnum);
      chk("words", (c >= 4 && c < 7) ? c - 3 : 0, fw);
      chk("none", c == 7, fnone);
    end
  endtask
  task automatic t_round();
    for (int m = 0; m < 4; m++) begin
      arith_status_reg = 2'(3 - m);
      hst.wr(2'h0, {UNIT, 6'h0, 1'b1, 1'(m), 1'(m >> 1), 15'h0});
      @(negedge clk);
      chk("command rounding", m, rm);
    end
    hst.wr(2'h0, {UNIT, 6'h0, 1'b0, 2'h3, 15'h0});
    for (int m = 0; m < 4; m++) begin
      arith_status_reg = 2'(m);
      repeat (2) @(negedge clk);
      chk("status rounding", m, rm);
    end
  endtask
  task automatic t_reg_read();
    logic [31:0] w, v;
    w = {UNIT, 3'h7, 3'h5, 1'b0, 2'h2, 5'h13, 3'h2, 7'h55};
    hst.wr(2'h0, w);
    rd_word(2'h0, v);
    chk("unused bits", {w[31:24], 3'h0, w[20:0]}, v);
    hst.wr(2'h0, {~UNIT, 24'h0});
    chk("foreign start", 96'h0, st);
    ce = 1'b0;
    hst.wr(2'h0, {UNIT, 24'h0});
    ce = 1'b1;
    chk("frozen start", 96'h0, st);
    rd_word(2'h0, v);
    chk("kept command", {w[31:24], 3'h0, w[20:0]}, v);
  endtask
  task automatic t_data();
    logic [31:0] v;
    for (int s = 1; s < 4; s++) begin
      hst.wr(2'(s), 32'hA5A5_0000 + s);
    end
    for (int s = 1; s < 4; s++) begin
      rd_word(2'(s), v);
      chk("data word", 32'hA5A5_0000 + s, v);
    end
  endtask
  task automatic t_exc();
    logic [31:0] lo, mid, hi;
    logic [95:0] e;
    for (int k = 0; k < 6; k++) begin
      case (k)
        0: e = {16'h0, op1};
        1, 2: e = {16'h0, op2};
        3: e = {lgrs, 10'h0, sg, ex, sig};
        4: e = {lgrs, 12'h0, op2};
        default: e = {lgrs, 12'h0, rnd};
      endcase
      @(negedge clk);
      {ev, t1, t2, oi} = {1'b1, k < 2, k == 1, k == 2};
      kind = (k < 3) ? 2'h0 : 2'(k - 2);
      @(negedge clk);
      ev = 1'b0;
      chk("held", 96'h1, fh);
      if (k == 3) hst.wr(2'h1, 32'h0); // Dropped while the trap data is unread
      rd_word(2'h1, lo);
      rd_word(2'h2, mid);
      rd_word(2'h3, hi);
      chk("trap data", e, {hi, mid, lo});
      chk("held after read", 96'h0, fh);
    end
  endtask
  task automatic t_coproc();
    @(negedge clk);
    {cv, cc} = {1'b1, UNIT, 24'h000380};
    @(negedge clk);
    {cv, iack} = 2'h1;
    chk("coproc", 96'h1, cm);
    @(negedge clk);
    iack = 1'b0;
    chk("abort", 96'h2, {ab, ta});
    hst.wr(2'h0, {UNIT, 24'h0});
    iack = 1'b1;
    @(negedge clk);
    iack = 1'b0;
    chk("ignored ack", 96'h1, {ab, ta});
    {cv, done} = 2'h2;
    @(negedge clk);
    {cv, done} = 2'h1;
    chk("coproc again", 96'h1, cm);
    @(negedge clk);
    done = 1'b0;
    chk("done ends", 96'h0, cm);
  endtask
  initial begin
    {rst_n, ce, cv, iack, done, ev, t1, t2, oi, sg} = 10'h101;
    {arith_status_reg, kind, cc, lgrs, ex} = {2'h0, 2'h0, 32'h0, 4'hA, 17'h1FFFE};
    op1 = {16'h7FFF, 64'h8123_4567_89AB_CDEF};
    op2 = {16'hFFFF, 64'hC000_0000_1357_9BDF};
    rnd = {16'h3FFF, 64'h8000_0000_0000_0001};
    sig = 64'h8765_4321_0FED_CBA9;
    do_reset();
    t_decode();
    t_round();
    t_reg_read();
    t_data();
    t_exc();
    t_coproc();
    @(negedge clk);
    ev = 1'b1;
    @(negedge clk);
    ev = 1'b0;
    chk("held before reset", 96'h1, fh);
    do_reset();
    chk("held after reset", 96'h0, fh);
    rd_word(2'h3, rst_word);
    chk("data after reset", 96'h0, rst_word);
    stop_test();
  end
endmodule
